/* dsgate_pkg.sv */
// dsgate_pkg: constants for the deep-sleep peripheral clock gating block
// assumes an apb slave at the system control base; offsets are byte addresses
package dsgate_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] RUN_GATE_OFS = 12'h104;
    localparam logic [11:0] SLEEP_GATE_OFS = 12'h114;
    localparam logic [11:0] DEEP_GATE_OFS = 12'h124;
    localparam logic [11:0] RUN_CFG_OFS = 12'h060;
    localparam logic [11:0] IRQ_STAT_OFS = 12'h200;
    localparam logic [11:0] IRQ_MASK_OFS = 12'h204;
    localparam logic [31:0] SYSCTL_BASE = 32'h400FE000;
    // ------------------------------------------------------------
    // fields
    // ------------------------------------------------------------
    localparam logic [31:0] GATE_IMPL_MASK = 32'h070F0013;
    localparam logic [31:0] GATE_RESET = 32'h00000000;
    localparam int AUTO_GATE_BIT = 27;
    localparam int NUM_PERIPH = 10;
    localparam int PERIPH_BITS = 4;
    // bit position of each gated unit, unit index 0..9
    localparam logic [9:0][4:0] PERIPH_POS = {5'h1A, 5'h19, 5'h18, 5'h13, 5'h12,
                                              5'h11, 5'h10, 5'h04, 5'h01, 5'h00};
    // interrupt status bits
    localparam int IRQ_FAULT_BIT = 0;
    localparam int IRQ_STATE_BIT = 1;
    localparam logic [31:0] IRQ_IMPL_MASK = 32'h00000003;
    // power states
    typedef enum logic [1:0] {DSG_RUN, DSG_SLEEP, DSG_DEEP} dsg_pstate_t;
endpackage

/* dsgate.sv */
// dsgate: run, sleep and deep-sleep peripheral clock gating registers
// assumes an apb master on i_clk and a power sequencer that drives i_pstate
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none

// Function
// RULE1 - each bit enables one peripheral clock
// RULE2 - access to gated peripheral returns bus fault
// RULE3 - all gating bits reset to zero
// RULE4 - three registers, power state selects one
// RULE5 - low-power registers used only with auto-gating
// RULE6 - deep-sleep register decodes at 0x124
// RULE7 - bit 26 gates analog comparator 2
// RULE8 - bits 31:27 read zero, read-only
// RULE9 - software enables needed peripherals after reset
// RULE10 - bits 19:16 gate timers 3..0
// RULE11 - bit 4 gates sync serial port 0
// RULE12 - bits 1,0 gate serial ports 1,0
// RULE13 - bits 25,24 gate comparators; others read zero
module dsgate (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // power state from the sequencer
    input wire logic [1:0] i_pstate,
    // peripheral access check
    input wire logic i_periph_req,
    input wire logic [3:0] i_periph_sel,
    output logic o_periph_fault,
    // clock enables, unit index order analog_cmp2_clk_en..serial_port0_clk_en
    output logic [9:0] o_clk_en,
    // interrupt
    output logic o_irq
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [31:0] run_gate_reg;
    logic [31:0] sleep_gate_reg;
    logic [31:0] deep_gate_reg;
    logic auto_gate_reg;
    logic [31:0] irq_stat_reg;
    logic [31:0] irq_mask_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic fault_reg;
    logic [9:0] clk_en_reg;
    logic irq_reg;
    logic [1:0] pstate_prev_reg;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    // compares use the full offset; anything unmatched answers with an error
    wire logic setup = i_psel && !i_penable;
    wire logic access = i_psel && i_penable && pready_reg;
    wire logic wr = access && i_pwrite;
    wire logic rd = access && !i_pwrite;
    wire logic hit_run = (i_paddr == dsgate_pkg::RUN_GATE_OFS);
    wire logic hit_sleep = (i_paddr == dsgate_pkg::SLEEP_GATE_OFS);
    wire logic hit_deep = (i_paddr == dsgate_pkg::DEEP_GATE_OFS); // RULE6
    wire logic hit_cfg = (i_paddr == dsgate_pkg::RUN_CFG_OFS);
    wire logic hit_stat = (i_paddr == dsgate_pkg::IRQ_STAT_OFS);
    wire logic hit_mask = (i_paddr == dsgate_pkg::IRQ_MASK_OFS);
    wire logic hit_any = hit_run | hit_sleep | hit_deep | hit_cfg | hit_stat | hit_mask;
    wire logic [31:0] wmask = i_pwdata & dsgate_pkg::GATE_IMPL_MASK; // RULE8 RULE13

    // read mux; reserved bits never stored so they read zero
    logic [31:0] rd_mux;
    always_comb begin
        if (hit_run) begin
            rd_mux = run_gate_reg;
        end else if (hit_sleep) begin
            rd_mux = sleep_gate_reg;
        end else if (hit_deep) begin
            rd_mux = deep_gate_reg; // RULE8
        end else if (hit_cfg) begin
            rd_mux = {4'h0, auto_gate_reg, 27'h0000000};
        end else if (hit_stat) begin
            rd_mux = irq_stat_reg;
        end else if (hit_mask) begin
            rd_mux = irq_mask_reg;
        end else begin
            rd_mux = 32'h00000000;
        end
    end

    // ------------------------------------------------------------
    // active gate selection
    // ------------------------------------------------------------
    // low-power registers only apply when auto gating is selected
    wire logic use_sleep = (i_pstate == 2'(dsgate_pkg::DSG_SLEEP)) && auto_gate_reg; // RULE5
    wire logic use_deep = (i_pstate == 2'(dsgate_pkg::DSG_DEEP)) && auto_gate_reg; // RULE5
    wire logic [31:0] active_gate = use_deep ? deep_gate_reg :
                                    (use_sleep ? sleep_gate_reg : run_gate_reg); // RULE4
    // one enable per unit, picked from its bit position in the active register
    logic [9:0] clk_en_next;
    genvar g;
    generate
        for (g = 0; g < dsgate_pkg::NUM_PERIPH; g++) begin : g_unit
            assign clk_en_next[g] = active_gate[dsgate_pkg::PERIPH_POS[g]]; // RULE1
        end
    endgenerate
    // an out-of-range unit number never indexes past the enable vector
    wire logic [3:0] sel_ok = (i_periph_sel < 4'(dsgate_pkg::NUM_PERIPH)) ?
                              i_periph_sel : 4'h0;
    wire logic fault_next = i_periph_req &&
                            ((i_periph_sel >= 4'(dsgate_pkg::NUM_PERIPH)) ||
                             !clk_en_reg[sel_ok]); // RULE2
    wire logic state_chg = (pstate_prev_reg != i_pstate);

    // ------------------------------------------------------------
    // gating registers
    // ------------------------------------------------------------
    // writes only land in implemented bits
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            run_gate_reg <= dsgate_pkg::GATE_RESET; // RULE3
            sleep_gate_reg <= dsgate_pkg::GATE_RESET;
            deep_gate_reg <= dsgate_pkg::GATE_RESET; // RULE3
            auto_gate_reg <= 1'b0;
        end else if (wr) begin
            if (hit_run) begin
                run_gate_reg <= wmask;
            end
            if (hit_sleep) begin
                sleep_gate_reg <= wmask;
            end
            if (hit_deep) begin
                deep_gate_reg <= wmask; // RULE7 RULE10 RULE11 RULE12 RULE13
            end
            if (hit_cfg) begin
                auto_gate_reg <= i_pwdata[dsgate_pkg::AUTO_GATE_BIT];
            end
        end
    end

    // clock enables and fault, registered so outputs come from flops
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            clk_en_reg <= 10'h000;
            fault_reg <= 1'b0;
            pstate_prev_reg <= 2'h0;
        end else begin
            clk_en_reg <= clk_en_next; // RULE1
            fault_reg <= fault_next; // RULE2
            pstate_prev_reg <= i_pstate;
        end
    end

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    // sticky events; a new event in the read-clear cycle survives
    wire logic [31:0] irq_ev = {30'h0, state_chg, fault_next};
    // clear only what the reader was shown: an event landing between setup
    // and access was not in the read data and must stay set
    wire logic [31:0] irq_clr = (rd && hit_stat) ? prdata_reg : 32'h00000000;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            irq_stat_reg <= 32'h00000000;
            irq_mask_reg <= 32'h00000000;
            irq_reg <= 1'b0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_ev;
            if (wr && hit_mask) irq_mask_reg <= i_pwdata & dsgate_pkg::IRQ_IMPL_MASK;
            irq_reg <= |(((irq_stat_reg & ~irq_clr) | irq_ev) & irq_mask_reg);
        end
    end

    // ------------------------------------------------------------
    // apb response
    // ------------------------------------------------------------
    // no wait state: pready rises the cycle after the setup phase
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
        end else if (setup) begin
            pready_reg <= 1'b1;
            pslverr_reg <= !hit_any;
            prdata_reg <= rd_mux;
        end else begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
        end
    end

    // every output is a flop, so nothing combinational reaches the pins
    assign o_prdata = prdata_reg;
    assign o_pready = pready_reg;
    assign o_pslverr = pslverr_reg;
    assign o_periph_fault = fault_reg;
    assign o_clk_en = clk_en_reg;
    assign o_irq = irq_reg;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_deep_write;
        wr && hit_deep;
    endsequence
    sequence s_deep_select;
        use_deep && !(wr && (hit_run | hit_sleep | hit_deep));
    endsequence

    a_reset_gates_zero: assert property (@(posedge i_clk) // RULE3
        i_rst |=> deep_gate_reg == 32'h00000000 && clk_en_reg == 10'h000)
        else $error("gates not zero after reset");
    a_reset_all_gates: assert property (@(posedge i_clk) // RULE3
        i_rst |=> (run_gate_reg | sleep_gate_reg) == 32'h00000000 && !auto_gate_reg)
        else $error("run or sleep gates not zero after reset");
    a_reset_quiet: assert property (@(posedge i_clk) // RULE3
        i_rst |=> !o_irq && !o_pready && !o_pslverr && !o_periph_fault)
        else $error("outputs not quiet after reset");
    a_deep_write_store: assert property (@(posedge i_clk) disable iff (i_rst) // RULE6
        s_deep_write |=> deep_gate_reg == ($past(i_pwdata) & 32'h070F0013))
        else $error("deep gate write not stored");
    a_reserved_read_zero: assert property (@(posedge i_clk) disable iff (i_rst) // RULE8
        deep_gate_reg[31:27] == 5'h00 && deep_gate_reg[15:5] == 11'h000)
        else $error("reserved bits set");
    a_cmp2_enable: assert property (@(posedge i_clk) disable iff (i_rst) // RULE7
        s_deep_select |=> o_clk_en[9] == $past(deep_gate_reg[26]))
        else $error("comparator 2 enable wrong");
    a_timer_enables: assert property (@(posedge i_clk) disable iff (i_rst) // RULE10
        s_deep_select |=> o_clk_en[6:3] == $past(deep_gate_reg[19:16]))
        else $error("timer enables wrong");
    a_sync_serial_en: assert property (@(posedge i_clk) disable iff (i_rst) // RULE11
        s_deep_select |=> o_clk_en[2] == $past(deep_gate_reg[4]))
        else $error("sync serial enable wrong");
    a_serial_port_en: assert property (@(posedge i_clk) disable iff (i_rst) // RULE12
        s_deep_select |=> o_clk_en[1:0] == $past(deep_gate_reg[1:0]))
        else $error("serial port enable wrong");
    a_cmp_low_en: assert property (@(posedge i_clk) disable iff (i_rst) // RULE13
        s_deep_select |=> o_clk_en[8:7] == $past(deep_gate_reg[25:24]))
        else $error("comparator 1/0 enables wrong");
    a_no_auto_run: assert property (@(posedge i_clk) disable iff (i_rst) // RULE5
        !auto_gate_reg |=> o_clk_en[1:0] == $past(run_gate_reg[1:0]))
        else $error("low-power gate used without auto gating");
    a_gated_fault: assert property (@(posedge i_clk) disable iff (i_rst) // RULE2
        (i_periph_req && i_periph_sel == 4'h0 && !o_clk_en[0]) |=> o_periph_fault)
        else $error("no fault on gated access");
    a_apb_one_wait: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_psel && !i_penable) |=> o_pready)
        else $error("apb answer late");

    // ------------------------------------------------------------
    // selection, bus answer and event checks
    // ------------------------------------------------------------
    sequence s_miss_setup;
        i_psel && !i_penable && !hit_any;
    endsequence
    sequence s_deep_read_setup;
        i_psel && !i_penable && !i_pwrite && hit_deep;
    endsequence
    sequence s_fault_clear;
        rd && hit_stat && prdata_reg[dsgate_pkg::IRQ_FAULT_BIT] && !fault_next;
    endsequence

    // states other than deep-sleep, and the auto gating switch
    a_sleep_select: assert property (@(posedge i_clk) disable iff (i_rst) // RULE4
        use_sleep |=> o_clk_en[2:0] == {$past(sleep_gate_reg[4]), $past(sleep_gate_reg[1:0])})
        else $error("sleep register not selected");
    a_run_select: assert property (@(posedge i_clk) disable iff (i_rst) // RULE4
        !(use_sleep || use_deep) |=> o_clk_en[9:7] == $past(run_gate_reg[26:24]))
        else $error("run register not selected");
    a_cfg_store: assert property (@(posedge i_clk) disable iff (i_rst) // RULE5
        (wr && hit_cfg) |=> auto_gate_reg == $past(i_pwdata[dsgate_pkg::AUTO_GATE_BIT]))
        else $error("auto gating select not stored");

    // stored gates keep unused bits clear and change only on their own write
    a_stored_mask: assert property (@(posedge i_clk) disable iff (i_rst) // RULE13
        ((run_gate_reg | sleep_gate_reg) & ~dsgate_pkg::GATE_IMPL_MASK) == 32'h00000000)
        else $error("unused gate bit stored");
    a_run_hold: assert property (@(posedge i_clk) disable iff (i_rst) // RULE4
        !(wr && hit_run) |=> $stable(run_gate_reg))
        else $error("run register changed without a write");
    a_sleep_hold: assert property (@(posedge i_clk) disable iff (i_rst) // RULE4
        !(wr && hit_sleep) |=> $stable(sleep_gate_reg))
        else $error("sleep register changed without a write");
    a_deep_hold: assert property (@(posedge i_clk) disable iff (i_rst) // RULE6
        !(wr && hit_deep) |=> $stable(deep_gate_reg))
        else $error("deep register changed without a write");

    // unit access check against the enables the unit sees
    a_fault_gated_any: assert property (@(posedge i_clk) disable iff (i_rst) // RULE2
        (i_periph_req && i_periph_sel == sel_ok && !o_clk_en[sel_ok]) |=> o_periph_fault)
        else $error("no fault on access to unclocked unit");
    a_enabled_no_fault: assert property (@(posedge i_clk) disable iff (i_rst) // RULE1
        (i_periph_req && i_periph_sel == sel_ok && o_clk_en[sel_ok]) |=> !o_periph_fault)
        else $error("fault on access to clocked unit");
    a_invalid_sel_fault: assert property (@(posedge i_clk) disable iff (i_rst) // RULE2
        (i_periph_req && i_periph_sel >= 4'(dsgate_pkg::NUM_PERIPH)) |=> o_periph_fault)
        else $error("no fault on access to missing unit");
    a_fault_needs_req: assert property (@(posedge i_clk) disable iff (i_rst) // RULE2
        o_periph_fault |-> $past(i_periph_req))
        else $error("fault without an access");

    // bus answer timing and error reporting
    a_unmapped_error: assert property (@(posedge i_clk) disable iff (i_rst)
        s_miss_setup |=> o_pready && o_pslverr && o_prdata == 32'h00000000)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_psel && !i_penable && hit_any) |=> o_pready && !o_pslverr)
        else $error("mapped access refused");
    a_pready_pulse: assert property (@(posedge i_clk) disable iff (i_rst)
        o_pready |=> !o_pready)
        else $error("ready held over two cycles");
    a_idle_bus_quiet: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_psel |=> !o_pready && o_prdata == 32'h00000000)
        else $error("bus answer without a request");
    a_deep_read_data: assert property (@(posedge i_clk) disable iff (i_rst) // RULE6
        s_deep_read_setup |=> o_prdata == $past(deep_gate_reg))
        else $error("deep register read data wrong");

    // event flags: set wins over the read clear, the line follows the mask
    a_mask_store: assert property (@(posedge i_clk) disable iff (i_rst)
        (wr && hit_mask) |=> irq_mask_reg == ($past(i_pwdata) & dsgate_pkg::IRQ_IMPL_MASK))
        else $error("mask write not stored");
    a_fault_sets_stat: assert property (@(posedge i_clk) disable iff (i_rst) // RULE2
        fault_next |=> irq_stat_reg[dsgate_pkg::IRQ_FAULT_BIT] && o_periph_fault)
        else $error("fault event not recorded");
    a_state_event: assert property (@(posedge i_clk) disable iff (i_rst)
        state_chg |=> irq_stat_reg[dsgate_pkg::IRQ_STATE_BIT])
        else $error("power state change not recorded");
    a_stat_sticky: assert property (@(posedge i_clk) disable iff (i_rst)
        (irq_stat_reg[0] && !(rd && hit_stat)) |=> irq_stat_reg[0])
        else $error("fault flag lost without a read");
    a_read_clears: assert property (@(posedge i_clk) disable iff (i_rst)
        s_fault_clear |=> !irq_stat_reg[dsgate_pkg::IRQ_FAULT_BIT])
        else $error("fault flag not cleared by read");
    a_irq_follows: assert property (@(posedge i_clk) disable iff (i_rst)
        o_irq == |(irq_stat_reg & $past(irq_mask_reg)))
        else $error("interrupt line does not follow flags");
endmodule

`default_nettype wire

/* dsgate_bench.sv */
// dsgate_bench: self-checking bench for the peripheral clock gating block
// assumes dsgate_pkg is compiled first; bench acts as apb master and unit requester
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module dsgate_bench;
    // ------------------------------------------------------------
    // signals and design
    // ------------------------------------------------------------
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, req = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, rq;
    logic pready, pslverr, re, fault, irq;
    logic [1:0] pstate = 2'h0;
    logic [3:0] sel = 4'h0;
    logic [9:0] clk_en;
    int n_fail = 0, tests_run = 0, cyc = 0;
    dsgate i_dut (.i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_pstate(pstate), .i_periph_req(req),
        .i_periph_sel(sel), .o_periph_fault(fault), .o_clk_en(clk_en), .o_irq(irq));
    // free-running 100 MHz clock
    initial begin
        forever #5 clk = ~clk;
    end
    // hang guard: whole run is well under a few thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            close_out();
        end
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // one apb transfer; read data and error land in rq and re
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rq = prdata;
        re = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    // enables follow register changes one cycle late, so let three edges pass
    task automatic settle();
        repeat (3) @(posedge clk);
    endtask
    // one-cycle access to unit u, returns the fault seen a cycle later
    task automatic probe(input logic [3:0] u, output logic f);
        @(posedge clk);
        req <= 1'b1; sel <= u;
        @(posedge clk);
        req <= 1'b0;
        @(posedge clk);
        f = fault;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        apb(0, dsgate_pkg::DEEP_GATE_OFS, 0);
        `CHK(rq, 32'h00000000)
        `CHK(clk_en, 9'h000)
        apb(1, dsgate_pkg::DEEP_GATE_OFS, 32'hFFFFFFFF);
        apb(0, dsgate_pkg::DEEP_GATE_OFS, 0);
        `CHK(rq, 32'h070F0013)
        `CHK(rq[31:27], 5'h00)
        apb(0, 12'h3F0, 0);
        `CHK({re, rq}, {1'b1, 32'h00000000})
    endtask
    task automatic t_units();
        logic f;
        apb(1, dsgate_pkg::RUN_CFG_OFS, 32'h08000000);
        pstate <= dsgate_pkg::DSG_DEEP;
        for (int i = 0; i < 10; i++) begin
            apb(1, dsgate_pkg::DEEP_GATE_OFS,
                32'h00000001 << dsgate_pkg::PERIPH_POS[i]);
            settle();
            `CHK(clk_en, 10'h001 << i)
            probe(i[3:0], f);
            `CHK(f, 1'b0)
            probe(4'((i + 1) % 10), f);
            `CHK(f, 1'b1)
        end
        probe(4'hF, f);
        `CHK(f, 1'b1)
        `CHK(irq, 1'b0) // masked fault keeps the line low
    endtask
    task automatic t_auto();
        apb(1, dsgate_pkg::RUN_GATE_OFS, 32'h00000002);
        apb(1, dsgate_pkg::RUN_CFG_OFS, 32'h00000000);
        settle();
        `CHK(clk_en, 10'h002)
        apb(1, dsgate_pkg::RUN_CFG_OFS, 32'h08000000);
        settle();
        `CHK(clk_en, 10'h200)
        apb(1, dsgate_pkg::SLEEP_GATE_OFS, 32'h00000010);
        pstate <= dsgate_pkg::DSG_SLEEP;
        settle();
        `CHK(clk_en, 10'h004)
    endtask
    task automatic t_irq();
        logic f;
        apb(0, dsgate_pkg::IRQ_STAT_OFS, 0);
        apb(1, dsgate_pkg::IRQ_MASK_OFS, 32'h00000001);
        probe(4'h0, f);
        settle();
        `CHK(irq, 1'b1)
        apb(0, dsgate_pkg::IRQ_STAT_OFS, 0);
        `CHK(rq[0], 1'b1)
        settle();
        `CHK(irq, 1'b0)
        apb(1, dsgate_pkg::IRQ_MASK_OFS, 32'h00000002);
        pstate <= 2'h3;
        settle();
        `CHK(irq, 1'b1)
        `CHK(clk_en, 10'h002)
        apb(0, dsgate_pkg::IRQ_STAT_OFS, 0);
        `CHK(rq[1:0], 2'h2)
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_units();
        t_auto();
        t_irq();
        close_out();
    end
endmodule
`default_nettype wire
